// File: dv/core_sequencer_asserts.sv
// port assertions for the instruction timing core
// assumes it is bound onto core_sequencer, one clock domain
`timescale 1ns/1ns
`default_nettype none

module core_sequencer_asserts
	import core_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic [PC_W-1:0] prog_addr,
	input wire logic [IW_W-1:0] prog_data,
	input wire logic [DW_W-1:0] dm_addr,
	input wire logic [DW_W-1:0] dm_rdata,
	input wire logic [DW_W-1:0] dm_wdata,
	input wire logic dm_we,
	input wire logic wake,
	input wire logic power_down,
	input wire logic wdt_clear,
	input wire logic int_enable,
	input wire logic [DW_W-1:0] acc,
	input wire logic flag_zero,
	input wire logic flag_carry,
	input wire logic [DW_W-1:0] table_high,
	input wire logic cycle_start
);
	// ========================================
	// reset release tracker
	// the core leaves its reset state one edge after its own two-stage
	// sync, so checks stay off until a third stage has filled
	logic [2:0] live_pipe; // release tracker

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			live_pipe <= 3'h0;
		end else begin
			live_pipe <= {live_pipe[1:0], 1'b1};
		end
	end

	// ========================================
	// framing of the instruction cycle
	default clocking @(posedge clock);
	endclocking
	default disable iff (!live_pipe[2]);

	a_cycle_single: assert property (cycle_start && ce |=> !cycle_start)
		else $error("cycle start longer than one clock");
	// four enabled clocks always bring the next phase zero
	a_cycle_four: assert property ((cycle_start && ce) ##1 ce [*3] |=> cycle_start || power_down)
		else $error("instruction cycle not four clocks");
	// addresses only move at the edge leaving phase zero
	a_addr_stable: assert property (!cycle_start && !power_down |=> $stable(prog_addr) && $stable(dm_addr))
		else $error("address moved inside a cycle");

	// ========================================
	// data memory writes
	a_we_pulse: assert property (dm_we && ce |=> !dm_we)
		else $error("write strobe longer than one clock");
	a_we_phase: assert property (dm_we |-> cycle_start)
		else $error("write outside cycle end");
	// pc low writes redirect, except a table read's, which is dropped, and never reach memory
	a_pcl_refused: assert property (dm_we |-> dm_addr != PCL_ADDR)
		else $error("pc low byte written to memory");

	// ========================================
	// halt and watchdog
	a_wdt_pulse: assert property (wdt_clear && ce |=> !wdt_clear)
		else $error("watchdog clear not a pulse");
	a_halt_quiet: assert property (power_down |-> !cycle_start && !dm_we)
		else $error("activity while halted");
	a_wake_exit: assert property (power_down && wake && ce |-> ##[1:8] !power_down)
		else $error("wake did not leave halt");

	c_write: cover property (dm_we);
	c_halt: cover property ($rose(power_down));
	c_interrupt_return: cover property ($rose(int_enable));
	c_wdt: cover property (wdt_clear);
endmodule

bind core_sequencer core_sequencer_asserts u_chk (
	.clock, .arst_n, .ce, .prog_addr, .prog_data, .dm_addr, .dm_rdata,
	.dm_wdata, .dm_we, .wake, .power_down, .wdt_clear, .int_enable, .acc,
	.flag_zero, .flag_carry, .table_high, .cycle_start
);
`default_nettype wire

// File: dv/mcu_instruction_timing_core_tb_top.sv
// self-checking bench for the instruction timing core
// assumes core_sequencer as top; program and data memory live here
`timescale 1ns/1ns
`default_nettype none

module mcu_instruction_timing_core_tb_top
	import core_pkg::*;
;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic ce = 1'b1; // random gaps freeze the core
	logic wake = 1'b0;
	logic [IW_W-1:0] prog_data = 16'h0000;
	logic [DW_W-1:0] dm_rdata = 8'h00;
	logic [PC_W-1:0] prog_addr;
	logic [DW_W-1:0] dm_addr, dm_wdata, acc, table_high;
	logic dm_we, power_down, wdt_clear, int_enable;
	logic flag_zero, flag_carry, cycle_start;
	logic [IW_W-1:0] rom [0:2**PC_W-1]; // program memory
	logic [DW_W-1:0] ram [0:255]; // data memory
	int failures = 0;
	int checked = 0;
	int seed = 8359;
	int wdt_n = 0; // watchdog pulses seen this run
	int base; // cycles of a lone halt

	always #20 clock = ~clock;

	core_sequencer u_dut (
		.clock, .arst_n, .ce, .prog_addr, .prog_data, .dm_addr,
		.dm_rdata, .dm_wdata, .dm_we, .wake, .power_down, .wdt_clear,
		.int_enable, .acc, .flag_zero, .flag_carry, .table_high,
		.cycle_start
	);

	// ========================================
	// memories answer at the falling edge, inside the two-clock window
	always @(negedge clock) begin
		if (dm_we)
			ram[dm_addr] = dm_wdata;
		if (wdt_clear)
			wdt_n++;
		prog_data <= rom[prog_addr];
		dm_rdata <= ram[dm_addr];
	end

	// ========================================
	// helpers
	function automatic logic [IW_W-1:0] ins(input logic [4:0] op,
		input logic [2:0] sel, input logic [7:0] v);
		return {op, sel, v};
	endfunction

	function automatic logic [7:0] exp_logic(input logic [1:0] v,
		input logic [7:0] a, input logic [7:0] m);
		case (v)
			LOG_AND: return a & m;
			LOG_OR: return a | m;
			LOG_XOR: return a ^ m;
			default: return ~m;
		endcase
	endfunction

	// carry enters as one; returns carry and result
	function automatic logic [8:0] exp_unary(input int k,
		input logic [7:0] m);
		case (k)
			0: return {1'b1, m + 8'h01};
			1: return {1'b1, m - 8'h01};
			2: return {1'b1, m[0], m[7:1]};
			3: return {1'b1, m[6:0], m[7]};
			4: return {m[0], 1'b1, m[7:1]};
			default: return {m[7], m[6:0], 1'b1};
		endcase
	endfunction

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		if (failures == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// empty program, random data bytes
	task automatic clear();
		foreach (rom[i])
			rom[i] = 16'h0000;
		foreach (ram[i])
			ram[i] = 8'($random(seed));
	endtask

	// reset, run to halt, count enabled phase-zero clocks
	task automatic run(input bit rnd, output int cyc);
		int n;
		cyc = 0;
		n = 0;
		arst_n = 1'b0;
		ce = 1'b1;
		wdt_n = 0;
		repeat (12) @(negedge clock);
		arst_n = 1'b1;
		while (power_down !== 1'b1 && n < 600) begin
			@(negedge clock);
			ce = rnd ? ($random(seed) % 4 != 0) : 1'b1;
			if (cycle_start && ce)
				cyc++;
			n++;
		end
		if (n >= 600)
			chk(16'h0001, 16'h0000);
	endtask

	task automatic wait_pd(input logic lvl);
		for (int n = 0; n < 50 && power_down !== lvl; n++)
			@(negedge clock);
	endtask

	// ========================================
	// main sequence
	initial begin
		logic [7:0] a, m, e;
		logic [8:0] s;
		logic c;
		int cyc, k;
		clear();
		rom[0] = ins(OP_HALT, 3'h0, 8'h00);
		run(1'b0, base);
		// arithmetic, first two are the carry and borrow corners
		for (int i = 0; i < 10; i++) begin
			a = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
			m = (i < 2) ? 8'h01 : 8'($random(seed));
			clear();
			ram[8'h21] = a;
			ram[8'h20] = m;
			rom[0] = ins(OP_MOV_AM, 3'h0, 8'h21);
			rom[1] = ins(OP_ARITH_M, {2'h0, i[0]}, 8'h20);
			rom[2] = ins(OP_MOV_MA, 3'h0, 8'h10);
			rom[3] = ins(OP_HALT, 3'h0, 8'h00);
			run(1'b1, cyc);
			s = i[0] ? {1'b0, a} - {1'b0, m} : {1'b0, a} + {1'b0, m};
			chk(acc, s[7:0]);
			chk(flag_carry, s[8] ^ i[0]);
			chk(flag_zero, s[7:0] == 8'h00);
			chk(ram[8'h10], s[7:0]);
		end
		// logic variants, upper half forced to a zero result
		for (int i = 0; i < 8; i++) begin
			a = i[2] ? 8'h00 : 8'($random(seed));
			m = i[2] ? {8{i[1:0] == 2'h3}} : 8'($random(seed));
			clear();
			ram[8'h20] = m;
			rom[0] = ins(OP_MOV_AX, 3'h0, a);
			rom[1] = ins(OP_LOGIC_M, {1'b0, i[1:0]}, 8'h20);
			rom[2] = ins(OP_HALT, 3'h0, 8'h00);
			run(1'b0, cyc);
			e = exp_logic(i[1:0], a, m);
			chk(acc, e);
			chk(flag_zero, e == 8'h00);
			chk(cyc - base, 2);
		end
		// inc, dec and four rotates with carry preset; wrap corners last
		for (int i = 0; i < 12; i++) begin
			k = i % 6;
			m = (i < 6) ? 8'($random(seed)) : {8{~i[0]}};
			clear();
			ram[8'h20] = m;
			rom[0] = ins(OP_MOV_AX, 3'h0, 8'h01);
			rom[1] = ins(OP_ARITH_X, 3'h0, 8'hff);
			rom[2] = ins(k < 2 ? OP_INCDEC : OP_ROTATE,
				k < 2 ? {2'h2, k[0]} : {1'b1, 2'(k - 2)}, 8'h20);
			rom[3] = ins(OP_HALT, 3'h0, 8'h00);
			run(1'b1, cyc);
			{c, e} = exp_unary(k, m);
			chk(acc, e);
			chk(flag_carry, c);
			chk(flag_zero, (k < 2) ? (e == 8'h00) : 1'b1);
		end
		// bit set and clear over every index
		for (int i = 0; i < 8; i++) begin
			m = 8'($random(seed));
			clear();
			ram[8'h30] = m;
			ram[8'h31] = m;
			rom[0] = ins(OP_SET_BIT, 3'(i), 8'h30);
			rom[1] = ins(OP_CLR_BIT, 3'(7 - i), 8'h31);
			rom[2] = ins(OP_HALT, 3'h0, 8'h00);
			run(1'b0, cyc);
			chk(ram[8'h30], m | (8'h01 << i));
			chk(ram[8'h31], m & ~(8'h01 << (7 - i)));
			chk(cyc - base, 2);
		end
		// branch program: 0xee loads must never execute
		clear();
		m = ram[8'h02];
		ram[8'h50] = 8'h00;
		ram[8'h51] = 8'h01;
		ram[8'h53] = 8'h88;
		ram[8'h54] = 8'hff;
		rom[11'h000] = ins(OP_MOV_AX, 3'h0, 8'h20);
		rom[11'h001] = ins(OP_MOV_MA, 3'h0, PCL_ADDR);
		rom[11'h020] = ins(OP_JUMP, 3'h0, 8'h30);
		rom[11'h030] = ins(OP_CALL, 3'h0, 8'h60);
		rom[11'h031] = ins(OP_SKIP_Z, 3'h0, 8'h50);
		rom[11'h032] = ins(OP_MOV_AX, 3'h0, 8'hee);
		rom[11'h033] = ins(OP_SKIP_Z, 3'h0, 8'h51);
		rom[11'h034] = ins(OP_MOV_AX, 3'h0, 8'h05);
		rom[11'h035] = ins(OP_TABLE_RD, 3'h0, 8'h52);
		rom[11'h036] = ins(OP_SKIP_BNZ, 3'h3, 8'h53);
		rom[11'h037] = ins(OP_MOV_AX, 3'h0, 8'hee);
		rom[11'h038] = ins(OP_SET_BIT, 3'h1, 8'h53);
		rom[11'h039] = ins(OP_CLR_BIT, 3'h3, 8'h53);
		rom[11'h03a] = ins(OP_SKIP_INC, 3'h0, 8'h54);
		rom[11'h03b] = ins(OP_MOV_AX, 3'h0, 8'hee);
		rom[11'h03c] = ins(OP_CALL, 3'h0, 8'h68);
		rom[11'h03d] = ins(OP_CLR_WDT, 3'h0, 8'h00);
		rom[11'h03e] = ins(OP_HALT, 3'h0, 8'h00);
		rom[11'h03f] = ins(OP_MOV_AX, 3'h0, 8'h99);
		rom[11'h040] = ins(OP_HALT, 3'h0, 8'h00);
		rom[11'h060] = ins(OP_MOV_AX, 3'h0, 8'h11);
		rom[11'h061] = ins(OP_RET, 3'h0, 8'h00);
		rom[11'h068] = ins(OP_INTERRUPT_RETURN, 3'h0, 8'h00);
		rom[11'h705] = 16'habcd;
		run(1'b0, cyc);
		// 3 pc low, 2 jump, 2+1+2 call, 2+1 skips, 1, 2 table,
		// 2+1+1 bit skip and bits, 2 inc skip, 2+2 call/interrupt_return, 1 wdt
		chk(cyc - base, 27);
		chk(acc, 8'h05);
		chk(ram[8'h02], m);
		chk(ram[8'h52], 8'hcd);
		chk(table_high, 8'hab);
		chk(ram[8'h53], 8'h82);
		chk(ram[8'h54], 8'h00);
		chk(int_enable, 1'b1);
		chk(wdt_n, 1);
		// wake resumes at the word after the halt
		wake = 1'b1;
		wait_pd(1'b0);
		wake = 1'b0;
		wait_pd(1'b1);
		chk(acc, 8'h99);
		chk(power_down, 1'b1);
		end_of_test();
	end

	// whole run is far below 20000 clocks; cut a hang there
	initial begin
		#800000;
		failures++;
		end_of_test();
	end
endmodule
`default_nettype wire

// File: rtl/core_alu.sv
// combinational byte alu of the instruction timing core
// assumes operands are stable for the whole execute phase
`timescale 1ns/1ns
`default_nettype none

module core_alu
	import core_pkg::*;
(
	input wire logic [4:0] op,
	input wire logic [2:0] sel,
	input wire logic [DW_W-1:0] acc,
	input wire logic [DW_W-1:0] mem,
	input wire logic [DW_W-1:0] imm,
	input wire logic carry_in,
	output logic [DW_W-1:0] result,
	output logic carry_out,
	output logic carry_update,
	output logic zero_update,
	output logic result_zero
);

	// ========================================
	// bit select mask
	logic [DW_W-1:0] mask; // one hot on the addressed bit

	genvar gi;
	generate
		for (gi = 0; gi < DW_W; gi = gi + 1) begin : g_mask
			assign mask[gi] = (sel == 3'(gi));
		end
	endgenerate

	// ========================================
	// operation select
	always_comb begin
		logic [DW_W-1:0] operand_b; // memory or immediate
		logic [DW_W:0] wide; // nine bit sum or difference
		logic cin_term; // carry or borrow brought in
		operand_b = (op == OP_ARITH_X || op == OP_LOGIC_X) ? imm : mem;
		cin_term = sel[SEL_CARRY] & (sel[SEL_DIR] ? ~carry_in : carry_in);
		wide = 9'h000;
		result = mem;
		carry_out = carry_in;
		carry_update = 1'b0;
		zero_update = 1'b0;
		case (op)
			OP_MOV_AX: begin
				result = imm;
			end
			OP_MOV_MA: begin
				result = acc;
			end
			OP_ARITH_M, OP_ARITH_X: begin
				// carry above 255, borrow below 0 clears carry
				if (sel[SEL_DIR]) begin
					wide = {1'b0, acc} - {1'b0, operand_b} - {8'h00, cin_term}; // see RULE_07
					carry_out = ~wide[DW_W];
				end else begin
					wide = {1'b0, acc} + {1'b0, operand_b} + {8'h00, cin_term}; // see RULE_07
					carry_out = wide[DW_W];
				end
				result = wide[DW_W-1:0];
				carry_update = 1'b1;
				zero_update = 1'b1;
			end
			OP_LOGIC_M, OP_LOGIC_X: begin
				case (sel[1:0])
					LOG_AND: result = acc & operand_b;
					LOG_OR: result = acc | operand_b;
					LOG_XOR: result = acc ^ operand_b;
					default: result = ~mem;
				endcase
				zero_update = 1'b1; // see RULE_09
			end
			OP_INCDEC, OP_SKIP_INC, OP_SKIP_DEC: begin
				// exactly one up or down, wrapping in eight bits
				if (sel[SEL_DIR] || op == OP_SKIP_DEC) begin
					result = mem - 8'h01; // see RULE_08
				end else begin
					result = mem + 8'h01; // see RULE_08
				end
				zero_update = (op == OP_INCDEC);
			end
			OP_ROTATE: begin
				// through-carry forms swap the end bit with carry
				if (sel[SEL_DIR]) begin
					result = {mem[DW_W-2:0], sel[SEL_CARRY] ? carry_in : mem[DW_W-1]}; // see RULE_10
					carry_out = sel[SEL_CARRY] ? mem[DW_W-1] : carry_in;
				end else begin
					result = {sel[SEL_CARRY] ? carry_in : mem[0], mem[DW_W-1:1]}; // see RULE_10
					carry_out = sel[SEL_CARRY] ? mem[0] : carry_in;
				end
				carry_update = sel[SEL_CARRY];
			end
			OP_SET_BIT: begin
				result = mem | mask; // see RULE_14
			end
			OP_CLR_BIT: begin
				result = mem & ~mask; // see RULE_14
			end
			default: begin
				result = mem;
			end
		endcase
		result_zero = (result == 8'h00);
	end

endmodule

`default_nettype wire

// File: rtl/core_pkg.sv
// constants shared by the instruction timing core and its alu
// assumes a 16-bit program word and an 8-bit data memory port
package core_pkg;

	// ========================================
	// word widths and sequencing
	localparam int PC_W = 11; // program address width
	localparam int IW_W = 16; // instruction word width
	localparam int DW_W = 8; // data byte width
	localparam logic [1:0] PHASE_LAST = 2'h3; // four clocks per cycle
	localparam logic [1:0] PHASE_FETCH = 2'h0; // addresses go out
	localparam logic [1:0] PHASE_SAMPLE = 2'h2; // read data taken
	localparam int STACK_DEPTH = 4; // return address slots
	localparam int SP_W = 2; // stack pointer width

	// ========================================
	// instruction word fields
	localparam int OP_HI = 15; // opcode top bit
	localparam int OP_LO = 11; // opcode low bit
	localparam int SEL_HI = 10; // variant or bit index top
	localparam int SEL_LO = 8; // variant or bit index low
	localparam int SEL_DEST = 2; // variant bit for the other destination
	localparam int SEL_CARRY = 1; // variant bit for with-carry forms
	localparam int SEL_DIR = 0; // variant bit: sub, dec or left

	// ========================================
	// reset values and fixed addresses
	localparam logic [PC_W-1:0] PC_RESET = 11'h000; // first fetch
	localparam logic [IW_W-1:0] IR_RESET = 16'h0000; // idle opcode
	localparam logic [DW_W-1:0] ACC_RESET = 8'h00; // accumulator
	localparam logic [DW_W-1:0] PCL_ADDR = 8'h02; // program counter low byte
	localparam logic [2:0] TABLE_PAGE = 3'h7; // table area, high pc bits

	// ========================================
	// opcodes
	localparam logic [4:0] OP_NOP = 5'h00; // no operation
	localparam logic [4:0] OP_MOV_AM = 5'h01; // memory to acc
	localparam logic [4:0] OP_MOV_MA = 5'h02; // acc to memory
	localparam logic [4:0] OP_MOV_AX = 5'h03; // immediate to acc
	localparam logic [4:0] OP_ARITH_M = 5'h04; // add or sub with memory
	localparam logic [4:0] OP_ARITH_X = 5'h05; // add or sub immediate
	localparam logic [4:0] OP_LOGIC_M = 5'h06; // and, or, xor, complement
	localparam logic [4:0] OP_LOGIC_X = 5'h07; // and, or, xor immediate
	localparam logic [4:0] OP_INCDEC = 5'h08; // increment or decrement
	localparam logic [4:0] OP_ROTATE = 5'h09; // rotate left or right
	localparam logic [4:0] OP_SET_BIT = 5'h0a; // set one bit
	localparam logic [4:0] OP_CLR_BIT = 5'h0b; // clear one bit
	localparam logic [4:0] OP_JUMP = 5'h0c; // jump_unconditional
	localparam logic [4:0] OP_CALL = 5'h0d; // subroutine call
	localparam logic [4:0] OP_RET = 5'h0e; // subroutine_return
	localparam logic [4:0] OP_INTERRUPT_RETURN = 5'h0f; // interrupt_return
	localparam logic [4:0] OP_SKIP_Z = 5'h10; // skip if byte zero
	localparam logic [4:0] OP_SKIP_BZ = 5'h11; // skip if bit zero
	localparam logic [4:0] OP_SKIP_BNZ = 5'h12; // skip if bit set
	localparam logic [4:0] OP_SKIP_INC = 5'h13; // increment, skip if zero
	localparam logic [4:0] OP_SKIP_DEC = 5'h14; // decrement, skip if zero
	localparam logic [4:0] OP_TABLE_RD = 5'h15; // read program memory
	localparam logic [4:0] OP_HALT = 5'h16; // enter power down
	localparam logic [4:0] OP_CLR_WDT = 5'h17; // service watchdog

	// logic variants in the low two select bits
	localparam logic [1:0] LOG_AND = 2'h0; // and
	localparam logic [1:0] LOG_OR = 2'h1; // or
	localparam logic [1:0] LOG_XOR = 2'h2; // xor
	localparam logic [1:0] LOG_CPL = 2'h3; // bitwise_complement

endpackage

// File: rtl/core_sequencer.sv
// instruction sequencer and execute stage of an 8-bit core
// assumes program and data memories answer within two clocks
//
// Notes on behaviour
// RULE_01 - most instructions finish in one cycle
// RULE_02 - jump, call, returns, table read take two
// RULE_03 - one instruction cycle is four clocks
// RULE_04 - writing the pc low byte costs one cycle
// RULE_05 - taken skip adds one cycle, else one
// RULE_06 - moves: memory to acc, acc to memory, immediate
// RULE_07 - carry above 255, borrow below zero
// RULE_08 - increment or decrement by exactly one
// RULE_09 - logic results set zero flag when zero
// RULE_10 - rotate one bit, carry forms through carry
// RULE_11 - call saves next address, return resumes there
// RULE_12 - jump loads target, saves nothing
// RULE_13 - skip tests a byte or a bit
// RULE_14 - bit set and clear rewrite other bits unchanged
// RULE_15 - table read fetches program memory into registers
// RULE_16 - halt powers down, watchdog clear instruction
// RULE_17 - discard prefetched word and refetch on redirect
`timescale 1ns/1ns
`default_nettype none

module core_sequencer
	import core_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic ce,
	output logic [PC_W-1:0] prog_addr,
	input wire logic [IW_W-1:0] prog_data,
	output logic [DW_W-1:0] dm_addr,
	input wire logic [DW_W-1:0] dm_rdata,
	output logic [DW_W-1:0] dm_wdata,
	output logic dm_we,
	input wire logic wake,
	output logic power_down,
	output logic wdt_clear,
	output logic int_enable,
	output logic [DW_W-1:0] acc,
	output logic flag_zero,
	output logic flag_carry,
	output logic [DW_W-1:0] table_high,
	output logic cycle_start
);

	// ========================================
	// types
	typedef enum logic [3:0] {
		ST_EXEC = 4'b0001, // execute ir, prefetch next
		ST_FLUSH = 4'b0010, // dummy cycle refetching
		ST_TABLE = 4'b0100, // second cycle of table read
		ST_HALT = 4'b1000 // power down, waiting for wake
	} state_t;

	typedef struct packed {
		state_t state; // sequencer state
		logic [1:0] phase; // clock within instruction cycle
		logic [PC_W-1:0] pc; // address of the next fetch
		logic [IW_W-1:0] ir; // instruction being executed
		logic [IW_W-1:0] fetched; // prefetched word
		logic [DW_W-1:0] rd; // operand read from memory
		logic [DW_W-1:0] acc; // accumulator
		logic zero; // zero flag
		logic carry; // carry flag
		logic [DW_W-1:0] table_high; // high byte of last table read
		logic [STACK_DEPTH-1:0][PC_W-1:0] stack; // return addresses
		logic [SP_W-1:0] sp; // next free stack slot
		logic [PC_W-1:0] prog_addr; // program memory address
		logic [DW_W-1:0] dm_addr; // data memory address
		logic [DW_W-1:0] dm_wdata; // data memory write byte
		logic dm_we; // write strobe
		logic wdt_clear; // watchdog service pulse
		logic int_enable; // global interrupt enable
	} core_t;

	localparam core_t CORE_RESET = '{
		state: ST_FLUSH, phase: 2'h0, pc: PC_RESET, ir: IR_RESET,
		fetched: IR_RESET, rd: 8'h00, acc: ACC_RESET, zero: 1'b0,
		carry: 1'b0, table_high: 8'h00, stack: '0, sp: 2'h0,
		prog_addr: PC_RESET, dm_addr: 8'h00, dm_wdata: 8'h00,
		dm_we: 1'b0, wdt_clear: 1'b0, int_enable: 1'b0
	};

	// ========================================
	// reset release
	logic [1:0] rst_pipe; // release synchroniser
	logic rst_n; // synchronised reset

	// two stages so release never lands near an edge
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe[1];

	// ========================================
	// state and decode
	core_t s; // registered state
	core_t n; // next state
	logic [4:0] op; // current opcode
	logic [2:0] sel; // variant or bit index
	logic [DW_W-1:0] opnd; // address or immediate
	logic [DW_W-1:0] alu_result; // alu output byte
	logic alu_carry; // alu carry out
	logic alu_cupd; // carry flag to update
	logic alu_zupd; // zero flag to update
	logic alu_zero; // alu result is zero

	assign op = s.ir[OP_HI:OP_LO];
	assign sel = s.ir[SEL_HI:SEL_LO];
	assign opnd = s.ir[DW_W-1:0];

	core_alu u_alu (
		.op(op),
		.sel(sel),
		.acc(s.acc),
		.mem(s.rd),
		.imm(opnd),
		.carry_in(s.carry),
		.result(alu_result),
		.carry_out(alu_carry),
		.carry_update(alu_cupd),
		.zero_update(alu_zupd),
		.result_zero(alu_zero)
	);

	// ========================================
	// next state
	always_comb begin
		logic to_mem; // result goes to data memory
		logic to_acc; // result goes to accumulator
		logic skip; // skip test passed
		logic redirect; // prefetched word is stale
		to_mem = 1'b0;
		to_acc = 1'b0;
		skip = 1'b0;
		redirect = 1'b0;
		n = s;
		n.dm_we = 1'b0; // strobes last one clock
		n.wdt_clear = 1'b0;

		// four clocks per instruction cycle, frozen in halt
		if (s.state != ST_HALT) begin
			n.phase = s.phase + 2'h1; // see RULE_03
		end

		// fetch and operand addresses go out at phase zero
		if (s.state != ST_HALT && s.phase == PHASE_FETCH) begin
			if (s.state == ST_TABLE) begin
				n.prog_addr = {TABLE_PAGE, s.acc}; // see RULE_15
			end else begin
				n.prog_addr = s.pc;
			end
			n.dm_addr = opnd;
		end

		// read data taken two clocks later
		if (s.state != ST_HALT && s.phase == PHASE_SAMPLE) begin
			if (s.state == ST_TABLE) begin
				n.rd = prog_data[DW_W-1:0]; // see RULE_15
				n.table_high = prog_data[IW_W-1:DW_W];
			end else begin
				n.fetched = prog_data;
				// reading pc low gives this instruction's address
				n.rd = (s.dm_addr == PCL_ADDR) ?
					8'((s.pc - 11'h001) & 11'h0ff) : dm_rdata;
			end
		end

		case (s.state)
			ST_EXEC: begin
				if (s.phase == PHASE_LAST) begin
					// default: single cycle, next word from prefetch
					n.ir = s.fetched; // see RULE_01
					n.pc = s.pc + 11'h001;
					to_mem = (op == OP_MOV_MA) || (op == OP_SET_BIT) ||
						(op == OP_CLR_BIT) ||
						((op == OP_ARITH_M || op == OP_LOGIC_M) &&
						sel[SEL_DEST]) ||
						((op == OP_INCDEC || op == OP_ROTATE ||
						op == OP_SKIP_INC || op == OP_SKIP_DEC) &&
						!sel[SEL_DEST]); // see RULE_06
					to_acc = (op == OP_MOV_AM) || (op == OP_MOV_AX) ||
						(op == OP_ARITH_X) || (op == OP_LOGIC_X) ||
						((op == OP_ARITH_M || op == OP_LOGIC_M) &&
						!sel[SEL_DEST]) ||
						((op == OP_INCDEC || op == OP_ROTATE ||
						op == OP_SKIP_INC || op == OP_SKIP_DEC ||
						op == OP_SKIP_Z) && sel[SEL_DEST]); // see RULE_06
					if (alu_cupd) begin
						n.carry = alu_carry;
					end
					if (alu_zupd) begin
						n.zero = alu_zero; // see RULE_09
					end
					if (to_acc) begin
						n.acc = alu_result;
					end
					if (to_mem) begin
						if (opnd == PCL_ADDR) begin
							// new low byte acts as a direct jump
							n.pc = {s.pc[PC_W-1:DW_W], alu_result}; // see RULE_04
							redirect = 1'b1;
						end else begin
							n.dm_we = 1'b1;
							n.dm_wdata = alu_result;
						end
					end
					case (op)
						OP_SKIP_Z, OP_SKIP_INC, OP_SKIP_DEC: begin
							skip = alu_zero; // see RULE_13
						end
						OP_SKIP_BZ: begin
							skip = ~s.rd[sel]; // see RULE_13
						end
						OP_SKIP_BNZ: begin
							skip = s.rd[sel]; // see RULE_13
						end
						OP_JUMP: begin
							n.pc = s.ir[PC_W-1:0]; // see RULE_12
							redirect = 1'b1; // see RULE_02
						end
						OP_CALL: begin
							// pc already points past the call
							n.stack[s.sp] = s.pc; // see RULE_11
							n.sp = s.sp + 2'h1;
							n.pc = s.ir[PC_W-1:0];
							redirect = 1'b1; // see RULE_02
						end
						OP_RET, OP_INTERRUPT_RETURN: begin
							n.sp = s.sp - 2'h1;
							n.pc = s.stack[s.sp - 2'h1]; // see RULE_11
							redirect = 1'b1; // see RULE_02
							if (op == OP_INTERRUPT_RETURN) begin
								n.int_enable = 1'b1;
							end
						end
						OP_TABLE_RD: begin
							// keep ir and pc, prefetch stays valid
							n.ir = s.ir;
							n.pc = s.pc;
							n.state = ST_TABLE; // see RULE_02
						end
						OP_HALT: begin
							n.state = ST_HALT; // see RULE_16
						end
						OP_CLR_WDT: begin
							n.wdt_clear = 1'b1; // see RULE_16
						end
						default: begin
						end
					endcase
					if (skip) begin
						// step over the prefetched word too
						n.pc = s.pc + 11'h001; // see RULE_05
						redirect = 1'b1;
					end
					if (redirect) begin
						// stale prefetch dropped, one dummy cycle
						n.ir = IR_RESET; // see RULE_17
						n.state = ST_FLUSH;
					end
				end
			end
			ST_FLUSH: begin
				if (s.phase == PHASE_LAST) begin
					n.ir = s.fetched; // see RULE_17
					n.pc = s.pc + 11'h001;
					n.state = ST_EXEC;
				end
			end
			ST_TABLE: begin
				if (s.phase == PHASE_LAST) begin
					// low byte to the addressed register, dropped when that is pc low
					if (opnd != PCL_ADDR) begin
						n.dm_we = 1'b1; // see RULE_15
						n.dm_wdata = s.rd;
					end
					n.ir = s.fetched;
					n.pc = s.pc + 11'h001;
					n.state = ST_EXEC;
				end
			end
			ST_HALT: begin
				// clock gating left to the system, we only wait
				n.phase = 2'h0;
				if (wake) begin
					n.state = ST_EXEC; // see RULE_16
				end
			end
			default: begin
				n.state = ST_FLUSH;
			end
		endcase
	end

	// ========================================
	// state register, frozen while ce is low
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s <= CORE_RESET;
		end else if (ce) begin
			s <= n;
		end
	end

	// ========================================
	// outputs
	assign prog_addr = s.prog_addr;
	assign dm_addr = s.dm_addr;
	assign dm_wdata = s.dm_wdata;
	assign dm_we = s.dm_we;
	assign power_down = (s.state == ST_HALT);
	assign wdt_clear = s.wdt_clear;
	assign int_enable = s.int_enable;
	assign acc = s.acc;
	assign flag_zero = s.zero;
	assign flag_carry = s.carry;
	assign table_high = s.table_high;
	assign cycle_start = (s.phase == PHASE_FETCH) && (s.state != ST_HALT);

endmodule

`default_nettype wire
